// [rtl/coa_defs.vh]
// Purpose: Constants for the operand addressing decoder.
// Assumes: Standard 8-bit core opcode map, byte-wide data paths.
// Notes:   Included by the decoder, the checker and the bench.
`ifndef COA_DEFS_VH
`define COA_DEFS_VH
`define COA_MODE_NONE     3'h0
`define COA_MODE_REG      3'h1
`define COA_MODE_DIRECT   3'h2
`define COA_MODE_INDIRECT 3'h3
`define COA_MODE_IMM      3'h4
`define COA_MODE_BASEIDX  3'h5
`define COA_SPACE_NONE    3'h0
`define COA_SPACE_IRAM    3'h1
`define COA_SPACE_SFR     3'h2
`define COA_SPACE_AUX     3'h3
`define COA_SPACE_XDATA   3'h4
`define COA_SPACE_CODE    3'h5
`define COA_SPACE_BIT     3'h6
`define COA_SPACE_ACCB    3'h7
`define COA_SFR_LIMIT     8'h80
`define COA_BIT_LIMIT     8'h80
`define COA_BIT_RAM_BASE  8'h20
`define COA_SFR_ACC       8'he0
`define COA_SFR_B         8'hf0
`define COA_STATUS_BYTE   8'hd0
`define COA_STATUS_BIT_LO 8'hd1
`define COA_STATUS_BIT_HI 8'hd7
`define COA_BANK_SHIFT    3
`define COA_PAGE_MASK     16'hf800
`define COA_OPC_LONG_JUMP      8'h02
`define COA_OPC_LONG_CALL     8'h12
`define COA_OPC_SHORT_JUMP      8'h80
`define COA_OPC_JMP_DATA_POINTER  8'h73
`define COA_OPC_MOVC_DATA_POINTER 8'h93
`define COA_OPC_MOVC_PC   8'h83
`define COA_OPC_MOV_DATA_POINTER  8'h90
`define COA_OPC_PUSH      8'hc0
`define COA_OPC_POP       8'hd0
`define COA_OPC_MOVX_RI   7'h71
`define COA_OPC_MOVX_RI_W 7'h79
`define COA_OPC_MOVX_DP   8'he0
`define COA_OPC_MOVX_DP_W 8'hf0
`define COA_OPC_MUL       8'ha4
`define COA_OPC_DIV       8'h84
`define COA_OPC_INC_DATA_POINTER  8'ha3
`define COA_ABS_LOW5      5'h01
`define COA_ABS_CALL_BIT  4
`endif

// [rtl/coa_target_adder.v]
// Purpose: Adds a base address and an offset for branch and table targets.
// Assumes: Offset is sign or zero extended here, as the caller selects with signed_offset.
// Notes:   Sum wraps within 64 Kbytes.
`timescale 1ns/100ps
module coa_target_adder (
    input  wire [15:0] base,
    input  wire [7:0]  offset,
    input  wire        signed_offset,
    output wire [15:0] sum
);
    wire [15:0] ext;
    assign ext = {{8{signed_offset & offset[7]}}, offset};
    assign sum = base + ext;
endmodule

// [rtl/coa_decoder.v]
// Purpose: Operand addressing decoder of an 8-bit core.
// Assumes: Opcode and operand bytes, pc of next instruction and core state are stable inputs.
// Notes:   All outputs registered; results appear one clock after the inputs.
`timescale 1ns/100ps
`include "coa_defs.vh"
module coa_decoder (
    input  wire        CLK,
    input  wire        RESETN,
    input  wire        OPCODE_VALID,
    input  wire [7:0]  OPCODE,
    input  wire [7:0]  OPERAND1,
    input  wire [7:0]  OPERAND2,
    input  wire [15:0] NEXT_PC,
    input  wire [1:0]  BANK_SELECT,
    input  wire [7:0]  WORKING_REGISTER0,
    input  wire [7:0]  WORKING_REGISTER1,
    input  wire [7:0]  STACK_POINTER,
    input  wire [15:0] DATA_POINTER,
    input  wire [7:0]  ACCUMULATOR,
    input  wire        AUX_SELECT,
    output reg         DECODE_VALID,
    output reg  [2:0]  SRC_MODE,
    output reg  [2:0]  SRC_SPACE,
    output reg  [15:0] SRC_ADDRESS,
    output reg  [2:0]  DST_MODE,
    output reg  [2:0]  DST_SPACE,
    output reg  [15:0] DST_ADDRESS,
    output reg         DST_READ,
    output reg  [15:0] IMMEDIATE,
    output reg         BRANCH,
    output reg         CALL,
    output reg  [15:0] BRANCH_TARGET,
    output reg         STATUS_WRITE
);
    reg  [2:0]  next_src_mode;
    reg  [2:0]  next_src_space;
    reg  [15:0] next_src_address;
    reg  [2:0]  next_dst_mode;
    reg  [2:0]  next_dst_space;
    reg  [15:0] next_dst_address;
    reg         next_dst_read;
    reg  [15:0] next_immediate;
    reg         next_branch;
    reg         next_call;
    reg  [15:0] next_target;
    reg         next_status;
    reg         is_move;
    reg  [7:0]  ri_value;
    reg  [7:0]  bit_byte;
    wire [7:0]  reg_addr;
    wire [15:0] rel_target;
    wire [15:0] table_target;
    wire [3:0]  lo;
    wire [3:0]  hi;
    wire        lookup_data_pointer;

    assign lo = OPCODE[3:0];
    assign hi = OPCODE[7:4];
    assign reg_addr = {3'h0, BANK_SELECT, OPCODE[2:0]};
    assign lookup_data_pointer = (OPCODE == `COA_OPC_MOVC_DATA_POINTER) || (OPCODE == `COA_OPC_JMP_DATA_POINTER);

    coa_target_adder u_rel (
        .base          (NEXT_PC),
        .offset        ((OPCODE[3:0] == 4'h4) || (OPCODE[3:0] == 4'h5) ? OPERAND2 : OPERAND1),
        .signed_offset (1'b1),
        .sum           (rel_target)
    );

    coa_target_adder u_table (
        .base          (lookup_data_pointer ? DATA_POINTER : NEXT_PC),
        .offset        (ACCUMULATOR),
        .signed_offset (1'b0),
        .sum           (table_target)
    );

    always @* begin
        ri_value = OPCODE[0] ? WORKING_REGISTER1 : WORKING_REGISTER0;
        bit_byte = (OPERAND1 < `COA_BIT_LIMIT) ?
                   (`COA_BIT_RAM_BASE + {3'h0, OPERAND1[6:2]} - {4'h0, OPERAND1[6:3]} * 8'h00
                    - {3'h0, OPERAND1[6:3], 1'b0} + {4'h0, OPERAND1[6:3]}) :
                   {OPERAND1[7:3], 3'h0};
        if (OPERAND1 < `COA_BIT_LIMIT) begin
            bit_byte = `COA_BIT_RAM_BASE + {4'h0, OPERAND1[6:3]};
        end
        is_move = (hi >= 4'h7 && hi <= 4'h8) || (hi >= 4'ha && hi <= 4'hf && hi != 4'hb
                   && hi != 4'hc && hi != 4'hd) || (OPCODE == `COA_OPC_MOV_DATA_POINTER);
        next_src_mode = `COA_MODE_NONE;
        next_src_space = `COA_SPACE_NONE;
        next_src_address = 16'h0000;
        next_dst_mode = `COA_MODE_NONE;
        next_dst_space = `COA_SPACE_NONE;
        next_dst_address = 16'h0000;
        next_immediate = {8'h00, OPERAND1};
        next_branch = 1'b0;
        next_call = 1'b0;
        next_target = 16'h0000;
        next_status = 1'b0;
        // Accumulator is the default destination of arithmetic and logic forms.
        if (lo >= 4'h4) begin
            next_dst_mode = `COA_MODE_REG;
            next_dst_space = `COA_SPACE_SFR;
            next_dst_address = {8'h00, `COA_SFR_ACC};
        end
        if (lo >= 4'h8) begin
            next_src_mode = `COA_MODE_REG;
            next_src_space = `COA_SPACE_IRAM;
            next_src_address = {8'h00, reg_addr};
        end else if (lo == 4'h6 || lo == 4'h7) begin
            next_src_mode = `COA_MODE_INDIRECT;
            next_src_space = `COA_SPACE_IRAM;
            next_src_address = {8'h00, ri_value};
        end else if (lo == 4'h5) begin
            next_src_mode = `COA_MODE_DIRECT;
            next_src_space = (OPERAND1 < `COA_SFR_LIMIT) ? `COA_SPACE_IRAM : `COA_SPACE_SFR;
            next_src_address = {8'h00, OPERAND1};
        end else if (lo == 4'h4) begin
            next_src_mode = `COA_MODE_IMM;
            next_src_space = `COA_SPACE_CODE;
        end
        // Increment and decrement work in place on their own operand.
        if ((hi == 4'h0 || hi == 4'h1) && lo >= 4'h5) begin
            next_dst_mode = next_src_mode;
            next_dst_space = next_src_space;
            next_dst_address = next_src_address;
        end
        // Accumulator-to-register moves write the operand named by the low nibble.
        if (hi == 4'hf && lo >= 4'h5) begin
            next_dst_mode = next_src_mode;
            next_dst_space = next_src_space;
            next_dst_address = next_src_address;
            next_src_mode = `COA_MODE_REG;
            next_src_space = `COA_SPACE_SFR;
            next_src_address = {8'h00, `COA_SFR_ACC};
        end
        // Moves of a constant or a direct byte write the operand named by the low nibble.
        if ((hi == 4'h7 && lo >= 4'h5) || (hi == 4'ha && lo >= 4'h6)) begin
            next_dst_mode = next_src_mode;
            next_dst_space = next_src_space;
            next_dst_address = next_src_address;
            if (hi == 4'h7) begin
                next_src_mode = `COA_MODE_IMM;
                next_src_space = `COA_SPACE_CODE;
                next_src_address = 16'h0000;
                if (lo == 4'h5) begin
                    next_immediate = {8'h00, OPERAND2};
                end
            end else begin
                next_src_mode = `COA_MODE_DIRECT;
                next_src_space = (OPERAND1 < `COA_SFR_LIMIT) ? `COA_SPACE_IRAM : `COA_SPACE_SFR;
                next_src_address = {8'h00, OPERAND1};
            end
        end
        if (lo == 4'h1) begin
            next_branch = 1'b1;
            next_call = OPCODE[`COA_ABS_CALL_BIT];
            next_target = (NEXT_PC & `COA_PAGE_MASK) | {5'h00, OPCODE[7:5], OPERAND1};
        end
        if (OPCODE == `COA_OPC_LONG_JUMP || OPCODE == `COA_OPC_LONG_CALL) begin
            next_branch = 1'b1;
            next_call = (OPCODE == `COA_OPC_LONG_CALL);
            next_target = {OPERAND1, OPERAND2};
        end
        if (OPCODE == `COA_OPC_SHORT_JUMP || (lo == 4'h0 && hi >= 4'h1 && hi <= 4'h7 && OPCODE[4])
            || (hi == 4'hb && lo >= 4'h4) || (hi == 4'hd && lo >= 4'h5)) begin
            next_branch = 1'b1;
            next_target = rel_target;
        end
        if (OPCODE == `COA_OPC_MOV_DATA_POINTER) begin
            next_src_mode = `COA_MODE_IMM;
            next_src_space = `COA_SPACE_CODE;
            next_immediate = {OPERAND1, OPERAND2};
            next_dst_mode = `COA_MODE_REG;
            next_dst_space = `COA_SPACE_NONE;
        end
        if (OPCODE == `COA_OPC_INC_DATA_POINTER) begin
            next_dst_mode = `COA_MODE_REG;
            next_dst_space = `COA_SPACE_NONE;
            next_dst_address = DATA_POINTER;
        end
        if (OPCODE == `COA_OPC_MUL || OPCODE == `COA_OPC_DIV) begin
            next_src_mode = `COA_MODE_REG;
            next_src_space = `COA_SPACE_ACCB;
            next_src_address = {`COA_SFR_B, `COA_SFR_ACC};
            next_dst_mode = `COA_MODE_REG;
            next_dst_space = `COA_SPACE_ACCB;
            next_dst_address = {`COA_SFR_B, `COA_SFR_ACC};
        end
        if (OPCODE == `COA_OPC_MOVC_DATA_POINTER || OPCODE == `COA_OPC_MOVC_PC) begin
            next_src_mode = `COA_MODE_BASEIDX;
            next_src_space = `COA_SPACE_CODE;
            next_src_address = table_target;
        end
        if (OPCODE == `COA_OPC_JMP_DATA_POINTER) begin
            next_branch = 1'b1;
            next_target = table_target;
        end
        if (OPCODE == `COA_OPC_PUSH) begin
            next_src_mode = `COA_MODE_DIRECT;
            next_src_space = (OPERAND1 < `COA_SFR_LIMIT) ? `COA_SPACE_IRAM : `COA_SPACE_SFR;
            next_src_address = {8'h00, OPERAND1};
            next_dst_mode = `COA_MODE_INDIRECT;
            next_dst_space = `COA_SPACE_IRAM;
            next_dst_address = {8'h00, STACK_POINTER + 8'h01};
        end
        if (OPCODE == `COA_OPC_POP) begin
            next_src_mode = `COA_MODE_INDIRECT;
            next_src_space = `COA_SPACE_IRAM;
            next_src_address = {8'h00, STACK_POINTER};
            next_dst_mode = `COA_MODE_DIRECT;
            next_dst_space = (OPERAND1 < `COA_SFR_LIMIT) ? `COA_SPACE_IRAM : `COA_SPACE_SFR;
            next_dst_address = {8'h00, OPERAND1};
        end
        if (OPCODE[7:1] == `COA_OPC_MOVX_RI || OPCODE[7:1] == `COA_OPC_MOVX_RI_W
            || OPCODE == `COA_OPC_MOVX_DP || OPCODE == `COA_OPC_MOVX_DP_W) begin
            if (OPCODE[4]) begin
                next_src_mode = `COA_MODE_REG;
                next_src_space = `COA_SPACE_SFR;
                next_src_address = {8'h00, `COA_SFR_ACC};
                next_dst_mode = `COA_MODE_INDIRECT;
                next_dst_space = AUX_SELECT ? `COA_SPACE_AUX : `COA_SPACE_XDATA;
                next_dst_address = OPCODE[1] ? {8'h00, ri_value} : DATA_POINTER;
            end else begin
                next_dst_mode = `COA_MODE_REG;
                next_dst_space = `COA_SPACE_SFR;
                next_dst_address = {8'h00, `COA_SFR_ACC};
                next_src_mode = `COA_MODE_INDIRECT;
                next_src_space = AUX_SELECT ? `COA_SPACE_AUX : `COA_SPACE_XDATA;
                next_src_address = OPCODE[1] ? {8'h00, ri_value} : DATA_POINTER;
            end
        end
        // Bit operands resolve to their byte in RAM or special register space.
        if (lo == 4'h2 && hi >= 4'h7 && hi != 4'he && hi != 4'hf) begin
            next_src_mode = `COA_MODE_DIRECT;
            next_src_space = `COA_SPACE_BIT;
            next_src_address = {OPERAND1, bit_byte};
        end
        if (next_dst_mode == `COA_MODE_IMM || next_dst_mode == `COA_MODE_BASEIDX) begin
            next_dst_mode = `COA_MODE_NONE;
        end
        next_dst_read = (next_dst_mode != `COA_MODE_NONE) && (next_src_mode != `COA_MODE_NONE)
                        && !is_move && (OPCODE != `COA_OPC_POP)
                        && (OPCODE != `COA_OPC_PUSH);
        // Bit writes are clear, set, complement and move from carry.
        next_status = (next_dst_space == `COA_SPACE_SFR
                       && next_dst_address[7:0] == `COA_STATUS_BYTE)
                      || (next_src_space == `COA_SPACE_BIT && lo == 4'h2
                       && (hi == 4'h9 || hi == 4'hb || hi == 4'hc || hi == 4'hd)
                       && OPERAND1 >= `COA_STATUS_BIT_LO
                       && OPERAND1 <= `COA_STATUS_BIT_HI);
    end

    always @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            DECODE_VALID <= 1'b0;
            SRC_MODE <= `COA_MODE_NONE;
            SRC_SPACE <= `COA_SPACE_NONE;
            SRC_ADDRESS <= 16'h0000;
            DST_MODE <= `COA_MODE_NONE;
            DST_SPACE <= `COA_SPACE_NONE;
            DST_ADDRESS <= 16'h0000;
            DST_READ <= 1'b0;
            IMMEDIATE <= 16'h0000;
            BRANCH <= 1'b0;
            CALL <= 1'b0;
            BRANCH_TARGET <= 16'h0000;
            STATUS_WRITE <= 1'b0;
        end else begin
            DECODE_VALID <= OPCODE_VALID;
            SRC_MODE <= next_src_mode;
            SRC_SPACE <= next_src_space;
            SRC_ADDRESS <= next_src_address;
            DST_MODE <= next_dst_mode;
            DST_SPACE <= next_dst_space;
            DST_ADDRESS <= next_dst_address;
            DST_READ <= OPCODE_VALID & next_dst_read;
            IMMEDIATE <= next_immediate;
            BRANCH <= OPCODE_VALID & next_branch;
            CALL <= OPCODE_VALID & next_call;
            BRANCH_TARGET <= next_target;
            STATUS_WRITE <= OPCODE_VALID & next_status;
        end
    end
endmodule

// [verification/coa_checker.sv]
// Purpose: Assertions on the operand decoder ports.
// Assumes: Outputs follow the taken inputs by exactly one clock.
// Notes:   Bound to every decoder instance.
`timescale 1ns/100ps
`include "coa_defs.vh"
module coa_checker (
    input wire        CLK,
    input wire        RESETN,
    input wire        OPCODE_VALID,
    input wire [7:0]  OPCODE,
    input wire [7:0]  OPERAND1,
    input wire [7:0]  OPERAND2,
    input wire [15:0] NEXT_PC,
    input wire [15:0] DATA_POINTER,
    input wire [7:0]  ACCUMULATOR,
    input wire        DECODE_VALID,
    input wire [2:0]  SRC_MODE,
    input wire [15:0] SRC_ADDRESS,
    input wire [2:0]  DST_MODE,
    input wire        DST_READ,
    input wire        CALL,
    input wire [15:0] BRANCH_TARGET,
    input wire        STATUS_WRITE
);
    reg [15:0] p_pc;
    reg [7:0]  p_op;
    reg [7:0]  p_op1;
    always @(posedge CLK) begin
        p_pc <= NEXT_PC;
        p_op <= OPCODE;
        p_op1 <= OPERAND1;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_take(op);
        OPCODE_VALID && OPCODE == op;
    endsequence
    a_valid_delay: assert property (OPCODE_VALID |=> DECODE_VALID)
        else $error("decode valid late");
    a_long_target: assert property (s_take(8'h02) |=>
        BRANCH_TARGET == {$past(OPERAND1), $past(OPERAND2)}) else $error("long target");
    a_long_call: assert property (s_take(8'h12) |=> CALL)
        else $error("long call flag");
    a_abs_page: assert property (OPCODE_VALID && OPCODE[4:0] == 5'h01 |=>
        BRANCH_TARGET == {p_pc[15:11], p_op[7:5], p_op1}) else $error("absolute target");
    a_short_rel: assert property (s_take(8'h80) |=>
        BRANCH_TARGET == p_pc + {{8{p_op1[7]}}, p_op1}) else $error("relative target");
    a_lookup_sum: assert property (s_take(8'h93) |=> SRC_MODE == `COA_MODE_BASEIDX
        && SRC_ADDRESS == $past(DATA_POINTER) + $past(ACCUMULATOR)) else $error("lookup");
    a_dst_legal: assert property (DECODE_VALID |->
        DST_MODE != `COA_MODE_IMM && DST_MODE != `COA_MODE_BASEIDX) else $error("dst mode");
    a_status_byte: assert property (OPCODE_VALID && OPCODE == 8'hf5 && OPERAND1 == 8'hd0 |=>
        STATUS_WRITE) else $error("status write missing");
    a_move_noread: assert property (OPCODE_VALID && OPCODE[7:3] == 5'h1d |=>
        !DST_READ) else $error("move reads dst");
    a_add_read: assert property (OPCODE_VALID && OPCODE[7:3] == 5'h05 |=>
        DST_READ) else $error("add skips dst");
endmodule
bind coa_decoder coa_checker u_chk (.CLK(CLK), .RESETN(RESETN),
    .OPCODE_VALID(OPCODE_VALID), .OPCODE(OPCODE), .OPERAND1(OPERAND1),
    .OPERAND2(OPERAND2), .NEXT_PC(NEXT_PC), .DATA_POINTER(DATA_POINTER),
    .ACCUMULATOR(ACCUMULATOR), .DECODE_VALID(DECODE_VALID), .SRC_MODE(SRC_MODE),
    .SRC_ADDRESS(SRC_ADDRESS), .DST_MODE(DST_MODE), .DST_READ(DST_READ), .CALL(CALL),
    .BRANCH_TARGET(BRANCH_TARGET), .STATUS_WRITE(STATUS_WRITE));

// [verification/coa_core_model.sv]
// Purpose: Core state seen by the decoder: RAM banks and pointers.
// Assumes: The bench loads the state between instructions.
// Notes:   Working registers come from the active bank.
`timescale 1ns/100ps
module coa_core_model (
    input  wire [1:0]  bank,
    output wire [7:0]  reg0,
    output wire [7:0]  reg1,
    output wire [7:0]  sp,
    output wire [7:0]  acc,
    output wire [15:0] data_pointer
);
    reg [7:0]  ram [0:127];
    reg [7:0]  sp_q;
    reg [7:0]  acc_q;
    reg [15:0] data_pointer_q;
    integer    i;
    initial begin
        for (i = 0; i < 128; i = i + 1) ram[i] = 8'h00;
        sp_q = 8'h07;
        acc_q = 8'h00;
        data_pointer_q = 16'h0000;
    end
    assign reg0 = ram[{2'h0, bank, 3'h0}];
    assign reg1 = ram[{2'h0, bank, 3'h1}];
    assign sp = sp_q;
    assign acc = acc_q;
    assign data_pointer = data_pointer_q;
endmodule

// [verification/tb_cpu_operand_addressing.sv]
// Purpose: Self-checking bench of the operand decoder.
// Assumes: Inputs change at the falling edge; results one clock later.
// Notes:   Core state comes from the core model.
`timescale 1ns/100ps
`include "coa_defs.vh"
module tb_cpu_operand_addressing;
    reg         CLK, RESETN, OPCODE_VALID, AUX_SELECT;
    reg  [7:0]  OPCODE, OPERAND1, OPERAND2;
    reg  [15:0] NEXT_PC;
    reg  [1:0]  BANK_SELECT;
    wire [7:0]  R0, R1, SP, ACC;
    wire [15:0] DP;
    wire        DECODE_VALID, DST_READ, BRANCH, CALL, STATUS_WRITE;
    wire [2:0]  SRC_MODE, SRC_SPACE, DST_MODE, DST_SPACE;
    wire [15:0] SRC_ADDRESS, DST_ADDRESS, IMMEDIATE, BRANCH_TARGET;
    integer     fail_count, comparisons;
    coa_core_model model (.bank(BANK_SELECT), .reg0(R0), .reg1(R1), .sp(SP),
        .acc(ACC), .data_pointer(DP));
    coa_decoder dut (.CLK(CLK), .RESETN(RESETN), .OPCODE_VALID(OPCODE_VALID),
        .OPCODE(OPCODE), .OPERAND1(OPERAND1), .OPERAND2(OPERAND2), .NEXT_PC(NEXT_PC),
        .BANK_SELECT(BANK_SELECT), .WORKING_REGISTER0(R0), .WORKING_REGISTER1(R1),
        .STACK_POINTER(SP), .DATA_POINTER(DP), .ACCUMULATOR(ACC), .AUX_SELECT(AUX_SELECT),
        .DECODE_VALID(DECODE_VALID), .SRC_MODE(SRC_MODE), .SRC_SPACE(SRC_SPACE),
        .SRC_ADDRESS(SRC_ADDRESS), .DST_MODE(DST_MODE), .DST_SPACE(DST_SPACE),
        .DST_ADDRESS(DST_ADDRESS), .DST_READ(DST_READ), .IMMEDIATE(IMMEDIATE),
        .BRANCH(BRANCH), .CALL(CALL), .BRANCH_TARGET(BRANCH_TARGET),
        .STATUS_WRITE(STATUS_WRITE));
    task chk(input [31:0] seen, input [31:0] exp, input [8*10-1:0] what);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task issue(input [7:0] op, input [7:0] a, input [7:0] b);
        begin
            OPCODE = op;
            OPERAND1 = a;
            OPERAND2 = b;
            OPCODE_VALID = 1'b1;
            @(negedge CLK);
        end
    endtask
    task t_branch;
        begin
            issue(8'h02, 8'h12, 8'h34);
            chk(BRANCH_TARGET, 16'h1234, "target");
            chk({BRANCH, CALL, DECODE_VALID}, 3'b101, "flags");
            issue(8'h12, 8'hab, 8'hcd);
            chk({CALL, BRANCH_TARGET}, {1'b1, 16'habcd}, "call");
            NEXT_PC = 16'h3abc;
            issue(8'he1, 8'h55, 8'h00);
            chk(BRANCH_TARGET, 16'h3f55, "abs");
            issue(8'hb1, 8'h01, 8'h00);
            chk({CALL, BRANCH_TARGET}, {1'b1, 16'h3d01}, "abscall");
            NEXT_PC = 16'h1000;
            issue(8'h80, 8'h80, 8'h00);
            chk(BRANCH_TARGET, 16'h0f80, "relneg");
            issue(8'h80, 8'h7f, 8'h00);
            chk(BRANCH_TARGET, 16'h107f, "relpos");
            $display("test branch done");
        end
    endtask
    task t_memory;
        begin
            model.data_pointer_q = 16'h1234;
            model.acc_q = 8'hff;
            issue(8'h93, 8'h00, 8'h00);
            chk({SRC_MODE, SRC_SPACE}, {`COA_MODE_BASEIDX, `COA_SPACE_CODE}, "lkmode");
            chk(SRC_ADDRESS, 16'h1333, "lkdptr");
            issue(8'h83, 8'h00, 8'h00);
            chk(SRC_ADDRESS, 16'h10ff, "lkpc");
            AUX_SELECT = 1'b1;
            issue(8'he0, 8'h00, 8'h00);
            chk({SRC_SPACE, SRC_ADDRESS}, {`COA_SPACE_AUX, 16'h1234}, "aux");
            AUX_SELECT = 1'b0;
            issue(8'he0, 8'h00, 8'h00);
            chk(SRC_SPACE, `COA_SPACE_XDATA, "xdata");
            model.sp_q = 8'h30;
            issue(8'hc0, 8'he0, 8'h00);
            chk(DST_ADDRESS, 16'h0031, "push");
            $display("test memory done");
        end
    endtask
    task t_operand;
        begin
            issue(8'h25, 8'h7f, 8'h00);
            chk({SRC_MODE, SRC_SPACE}, {`COA_MODE_DIRECT, `COA_SPACE_IRAM}, "dirlo");
            chk({DST_READ, SRC_ADDRESS}, {1'b1, 16'h007f}, "diraddr");
            issue(8'h25, 8'h80, 8'h00);
            chk(SRC_SPACE, `COA_SPACE_SFR, "dirhi");
            issue(8'he5, 8'h80, 8'h00);
            chk(DST_READ, 1'b0, "movread");
            BANK_SELECT = 2'h2;
            model.ram[8'h11] = 8'h42;
            issue(8'h2d, 8'h00, 8'h00);
            chk({SRC_MODE, SRC_ADDRESS}, {`COA_MODE_REG, 16'h0015}, "bankreg");
            issue(8'h27, 8'h00, 8'h00);
            chk({SRC_MODE, SRC_ADDRESS}, {`COA_MODE_INDIRECT, 16'h0042}, "indir");
            issue(8'he9, 8'h00, 8'h00);
            chk({SRC_MODE, SRC_ADDRESS, DST_READ}, {`COA_MODE_REG, 16'h0011, 1'b0}, "movreg");
            issue(8'h90, 8'hab, 8'hcd);
            chk(IMMEDIATE, 16'habcd, "imm16");
            issue(8'h24, 8'h5a, 8'h00);
            chk({SRC_MODE, IMMEDIATE}, {`COA_MODE_IMM, 16'h005a}, "imm8");
            chk(DST_MODE, `COA_MODE_REG, "immdst");
            issue(8'ha4, 8'h00, 8'h00);
            chk({SRC_SPACE, SRC_ADDRESS}, {`COA_SPACE_ACCB, 16'hf0e0}, "mulpair");
            issue(8'h75, 8'hd0, 8'h3c);
            chk({DST_MODE, DST_SPACE, IMMEDIATE}, {`COA_MODE_DIRECT, `COA_SPACE_SFR, 16'h003c}, "movimm");
            chk(STATUS_WRITE, 1'b1, "psmovimm");
            $display("test operand done");
        end
    endtask
    task t_status;
        begin
            issue(8'hf5, 8'hd0, 8'h00);
            chk(STATUS_WRITE, 1'b1, "psbyte");
            issue(8'hf5, 8'hd1, 8'h00);
            chk(STATUS_WRITE, 1'b0, "otherbyte");
            issue(8'hd2, 8'hd3, 8'h00);
            chk(STATUS_WRITE, 1'b1, "psbit");
            chk(SRC_ADDRESS, 16'hd3d0, "bitsfr");
            issue(8'hc2, 8'h2b, 8'h00);
            chk(SRC_ADDRESS, 16'h2b25, "bitram");
            issue(8'hb2, 8'hd5, 8'h00);
            chk(STATUS_WRITE, 1'b1, "pscpl");
            issue(8'h92, 8'hd4, 8'h00);
            chk(STATUS_WRITE, 1'b1, "psmovbit");
            issue(8'hc2, 8'hd0, 8'h00);
            chk(STATUS_WRITE, 1'b0, "parity");
            $display("test status done");
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", comparisons, fail_count);
            if (fail_count == 0 && comparisons > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        repeat (2000) @(posedge CLK);
        fail_count = fail_count + 1;
        end_of_test;
    end
    initial begin
        fail_count = 0;
        comparisons = 0;
        RESETN = 1'b0;
        OPCODE_VALID = 1'b0;
        AUX_SELECT = 1'b0;
        OPCODE = 8'h00;
        OPERAND1 = 8'h00;
        OPERAND2 = 8'h00;
        NEXT_PC = 16'h0000;
        BANK_SELECT = 2'h0;
        repeat (3) @(negedge CLK);
        RESETN = 1'b1;
        @(negedge CLK);
        t_branch;
        t_memory;
        t_operand;
        t_status;
        end_of_test;
    end
endmodule
